// ===== hdl/cppc_pkg.sv
`default_nettype none
package cppc_pkg;
  // ****************************************************************
  // control bit positions
  // ****************************************************************
  localparam int unsigned CAN_HOLD_BIT = 0;
  localparam int unsigned REF_DIR_BIT = 5;
  localparam int unsigned CTRL_W = 8;
  // ****************************************************************
  // port pin positions and reset values
  // ****************************************************************
  localparam int unsigned TX_A_BIT = 6;
  localparam int unsigned TX_B_BIT = 7;
  localparam int unsigned CAP_W = 4;
  localparam int unsigned EVT_BIT = 4;
  localparam int unsigned RST_BIT = 5;
  localparam int unsigned SR_W = 6;
  localparam int unsigned TOG_LO = 6;
  localparam logic [7:0] PORT_RST = 8'hff;
  localparam logic [7:0] CTRL_RST = 8'h21;
  localparam int unsigned SYNC_STAGES = 2;
endpackage : cppc_pkg
`default_nettype wire

// ===== hdl/cppc_rx_if.sv
`default_nettype none
// ****************************************************************
// receive comparator path between top and synchroniser
// ****************************************************************
interface cppc_rx_if;
  logic cmp_raw;
  logic cmp_sync;
  modport src (output cmp_raw, input cmp_sync);
  modport dst (input cmp_raw, output cmp_sync);
endinterface : cppc_rx_if
`default_nettype wire

// ===== hdl/cppc_sync.sv
`default_nettype none
module cppc_sync (
  // clock and reset
  input wire logic clk_sys_i,
  input wire logic rst_n_i,
  // level to synchronise
  cppc_rx_if.dst rx
);
  logic [cppc_pkg::SYNC_STAGES-1:0] sh_r;
  logic [cppc_pkg::SYNC_STAGES-1:0] sh_nxt;
  // shift chain; first stage is read only by the second
  always_comb begin
    sh_nxt = {sh_r[cppc_pkg::SYNC_STAGES-2:0], rx.cmp_raw};
  end
  // resets recessive so the engine sees an idle bus
  always_ff @(posedge clk_sys_i) begin
    if (!rst_n_i) begin
      sh_r <= '1;
    end else begin
      sh_r <= sh_nxt;
    end
  end
  assign rx.cmp_sync = sh_r[cppc_pkg::SYNC_STAGES-1];
endmodule : cppc_sync
`default_nettype wire

// ===== hdl/cppc_top.sv
// Function
// - ref pin direction follows control bit five
// - external reset: reference on, pin output
// - reference off in powerdown while can reset
// - pos above neg reads recessive one
// - pos below neg reads dominant zero
// - can held reset: tx float, open-drain
// - power-up reset sets tx latch bits high
// - port1 bits 0-3 capture or irq inputs
// - port1 bits 4,5 timer2 rising edge inputs
// - port4 compare setreset and toggle outputs
// - port0 open-drain, muxed low addr data
// - port2 high address or quasi-bidirectional
// - alternate function only when enable bit set
`default_nettype none
module cppc_top (
  // clock and reset
  input wire logic clk_sys_i,
  input wire logic rst_n_i,
  // cpu side control
  input wire logic [7:0] can_ctrl_i,
  input wire logic powerdown_i,
  input wire logic ext_mem_i,
  input wire logic ext_addr_phase_i,
  input wire logic [15:0] ext_addr_i,
  input wire logic [7:0] ext_wdata_i,
  input wire logic ext_wr_i,
  input wire logic [7:0] p0_latch_i,
  input wire logic [7:0] p1_latch_i,
  input wire logic [7:0] p2_latch_i,
  input wire logic [7:0] p4_latch_i,
  input wire logic [7:0] p1_alt_en_i,
  input wire logic [7:0] p4_alt_en_i,
  // can engine side
  input wire logic can_tx_a_i,
  input wire logic can_tx_b_i,
  output logic can_rx_bit_o,
  // timer2 side
  input wire logic [5:0] cmp_sr_i,
  input wire logic [1:0] cmp_tog_i,
  output logic [3:0] capture_or_irq_o,
  output logic timer2_event_rise_o,
  output logic timer2_reset_rise_o,
  // analog and pins
  input wire logic can_rx_pos_above_neg_i,
  output logic ref_out_en_o,
  output logic ref_source_on_o,
  input wire logic [7:0] p0_pin_i,
  output logic [7:0] p0_o,
  output logic [7:0] p0_oe_o,
  output logic [7:0] p0_rdata_o,
  input wire logic [7:0] p1_pin_i,
  output logic [7:0] p1_o,
  output logic [7:0] p1_oe_o,
  output logic [7:0] p2_o,
  output logic [7:0] p2_oe_o,
  output logic [7:0] p4_o,
  output logic [7:0] p4_oe_o
);
  // every check samples on the system clock and sleeps during reset
  default clocking cppc_cb @(posedge clk_sys_i);
  endclocking
  default disable iff (!rst_n_i);
  // ****************************************************************
  // receive comparator synchroniser
  // ****************************************************************
  cppc_rx_if rx ();
  assign rx.cmp_raw = can_rx_pos_above_neg_i;
  cppc_sync u_sync (
    .clk_sys_i(clk_sys_i),
    .rst_n_i(rst_n_i),
    .rx(rx.dst)
  );
  // ****************************************************************
  // next-state computation
  // ****************************************************************
  logic [7:0] ctrl_r, ctrl_nxt;
  logic rx_r, rx_nxt, refoe_r, refoe_nxt, refon_r, refon_nxt;
  logic [7:0] p0o_r, p0o_nxt, p0oe_r, p0oe_nxt, p0rd_r, p0rd_nxt;
  logic [7:0] p1o_r, p1o_nxt, p1oe_r, p1oe_nxt;
  logic [7:0] p2o_r, p2o_nxt, p2oe_r, p2oe_nxt;
  logic [7:0] p4o_r, p4o_nxt, p4oe_r, p4oe_nxt, p1pin_r;
  logic [3:0] cap_r, cap_nxt;
  logic evt_r, evt_nxt, rt_r, rt_nxt;
  logic can_held;
  assign can_held = ctrl_r[cppc_pkg::CAN_HOLD_BIT];
  // compare outputs in pin order: set/reset low, toggle in the top two
  logic [7:0] p4_cmp;
  assign p4_cmp = {cmp_tog_i, cmp_sr_i};
  always_comb begin
    ctrl_nxt = can_ctrl_i;
    rx_nxt = rx.cmp_sync;
    refoe_nxt = ctrl_r[cppc_pkg::REF_DIR_BIT];
    // source runs unless the engine is parked and chip sleeps
    refon_nxt = !(can_held && powerdown_i);
    // port0: drives only low as a port; drives both levels on the bus
    p0o_nxt = ext_mem_i ? (ext_addr_phase_i ? ext_addr_i[7:0]
                                            : ext_wdata_i) : 8'h00;
    p0oe_nxt = ext_mem_i ? ((ext_addr_phase_i || ext_wr_i) ? 8'hff
                                                            : 8'h00)
                         : ~p0_latch_i;
    p0rd_nxt = p0_pin_i;
    // port2: high address during external access
    p2o_nxt = ext_mem_i ? ext_addr_i[15:8] : p2_latch_i;
    p2oe_nxt = ext_mem_i ? 8'hff : ~p2_latch_i;
    p1o_nxt = 8'h00;
    p1oe_nxt = 8'h00;
    p4o_nxt = 8'h00;
    p4oe_nxt = 8'h00;
    for (int i = 0; i < 8; i++) begin
      // quasi-bidirectional: strong low, weak high left to pullup
      p1o_nxt[i] = 1'b0;
      p1oe_nxt[i] = !p1_latch_i[i];
      p4o_nxt[i] = 1'b0;
      p4oe_nxt[i] = !p4_latch_i[i];
      if (p4_alt_en_i[i] && p4_latch_i[i]) begin
        p4o_nxt[i] = p4_cmp[i];
        p4oe_nxt[i] = 1'b1;
      end
    end
    // transmit pins: engine drives them when their enable bit is set, unless held in reset
    if (!can_held && p1_alt_en_i[cppc_pkg::TX_A_BIT]) begin
      p1o_nxt[cppc_pkg::TX_A_BIT] = can_tx_a_i;
      p1oe_nxt[cppc_pkg::TX_A_BIT] = 1'b1;
    end
    if (!can_held && p1_alt_en_i[cppc_pkg::TX_B_BIT]) begin
      p1o_nxt[cppc_pkg::TX_B_BIT] = can_tx_b_i;
      p1oe_nxt[cppc_pkg::TX_B_BIT] = 1'b1;
    end // otherwise open-drain from the latch
    for (int i = 0; i < cppc_pkg::CAP_W; i++) begin
      cap_nxt[i] = p1_alt_en_i[i] && p1_pin_i[i];
    end
    // rising edges only; pins assumed synchronous
    evt_nxt = p1_alt_en_i[cppc_pkg::EVT_BIT] && p1_pin_i[cppc_pkg::EVT_BIT]
              && !p1pin_r[cppc_pkg::EVT_BIT];
    rt_nxt = p1_alt_en_i[cppc_pkg::RST_BIT] && p1_pin_i[cppc_pkg::RST_BIT]
             && !p1pin_r[cppc_pkg::RST_BIT];
  end
  // ****************************************************************
  // registers
  // ****************************************************************
  always_ff @(posedge clk_sys_i) begin
    if (!rst_n_i) begin
      ctrl_r <= cppc_pkg::CTRL_RST; // engine held, ref out
      rx_r <= 1'b1;
      refoe_r <= 1'b1;
      refon_r <= 1'b1;
      p0o_r <= 8'h00;
      p0oe_r <= 8'h00;
      p0rd_r <= 8'h00;
      p1o_r <= 8'h00;
      p1oe_r <= 8'h00; // latches high: tx pins float
      p2o_r <= cppc_pkg::PORT_RST;
      p2oe_r <= 8'h00;
      p4o_r <= 8'h00;
      p4oe_r <= 8'h00;
      p1pin_r <= cppc_pkg::PORT_RST;
      cap_r <= 4'h0;
      evt_r <= 1'b0;
      rt_r <= 1'b0;
    end else begin
      ctrl_r <= ctrl_nxt;
      rx_r <= rx_nxt;
      refoe_r <= refoe_nxt;
      refon_r <= refon_nxt;
      p0o_r <= p0o_nxt;
      p0oe_r <= p0oe_nxt;
      p0rd_r <= p0rd_nxt;
      p1o_r <= p1o_nxt;
      p1oe_r <= p1oe_nxt;
      p2o_r <= p2o_nxt;
      p2oe_r <= p2oe_nxt;
      p4o_r <= p4o_nxt;
      p4oe_r <= p4oe_nxt;
      p1pin_r <= p1_pin_i;
      cap_r <= cap_nxt;
      evt_r <= evt_nxt;
      rt_r <= rt_nxt;
    end
  end
  // ****************************************************************
  // outputs
  // ****************************************************************
  assign can_rx_bit_o = rx_r;
  assign ref_out_en_o = refoe_r;
  assign ref_source_on_o = refon_r;
  assign p0_o = p0o_r;
  assign p0_oe_o = p0oe_r;
  assign p0_rdata_o = p0rd_r;
  assign p1_o = p1o_r;
  assign p1_oe_o = p1oe_r;
  assign p2_o = p2o_r;
  assign p2_oe_o = p2oe_r;
  assign p4_o = p4o_r;
  assign p4_oe_o = p4oe_r;
  assign capture_or_irq_o = cap_r;
  assign timer2_event_rise_o = evt_r;
  assign timer2_reset_rise_o = rt_r;
  // ****************************************************************
  // checks
  // ****************************************************************
  // a rising edge is a pin sampled low, then high with its enable set
  sequence s_evt_rise;
    !p1_pin_i[cppc_pkg::EVT_BIT] ##1
      (p1_pin_i[cppc_pkg::EVT_BIT] && p1_alt_en_i[cppc_pkg::EVT_BIT]);
  endsequence
  sequence s_rt_rise;
    !p1_pin_i[cppc_pkg::RST_BIT] ##1
      (p1_pin_i[cppc_pkg::RST_BIT] && p1_alt_en_i[cppc_pkg::RST_BIT]);
  endsequence
  a_ref_dir: assert property (
    ##1 ref_out_en_o == $past(ctrl_r[cppc_pkg::REF_DIR_BIT]))
    else $error("ref direction wrong");
  a_ref_off: assert property (
    (can_held && powerdown_i) |=> !ref_source_on_o)
    else $error("ref source not off");
  a_rx_sync: assert property (
    ##3 can_rx_bit_o == $past(can_rx_pos_above_neg_i, 3))
    else $error("rx latency wrong");
  a_tx_float: assert property (
    can_held |=> !p1_oe_o[cppc_pkg::TX_A_BIT]
      || p1_o[cppc_pkg::TX_A_BIT] == 1'b0)
    else $error("tx driven high while held");
  a_p2_addr: assert property (
    ext_mem_i |=> p2_o == $past(ext_addr_i[15:8]) && p2_oe_o == 8'hff)
    else $error("high address missing");
  a_evt_edge: assert property (
    timer2_event_rise_o |-> $past(p1_pin_i[cppc_pkg::EVT_BIT])
      && !$past(p1_pin_i[cppc_pkg::EVT_BIT], 2))
    else $error("event not rising edge");
  a_evt_fire: assert property (s_evt_rise |=> timer2_event_rise_o)
    else $error("event edge missed");
  a_rt_fire: assert property (s_rt_rise |=> timer2_reset_rise_o)
    else $error("timer reset edge missed");
  a_p0_odrain: assert property (
    !ext_mem_i |=> p0_o == 8'h00)
    else $error("port0 drives high");
  a_p4_alt: assert property (
    !p4_alt_en_i[0] |=> p4_o[0] == 1'b0)
    else $error("alt without enable");
endmodule : cppc_top
`default_nettype wire

// ===== sim/cppc_far_model.sv
`default_nettype none
module cppc_far_model (
  // clock
  input wire logic clk_sys_i,
  // bus level and memory request
  input wire logic bus_bit_i,
  input wire logic rd_sel_i,
  input wire logic [15:0] addr_i,
  // answers
  output logic pos_above_neg_o,
  output logic [7:0] mem_data_o
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [7:0] last_r = 8'h00;
  // recessive one lifts pos over neg, dominant zero pulls it below
  assign pos_above_neg_o = bus_bit_i;
  // released lines flip every cycle so a stale byte never reads as valid
  assign mem_data_o = rd_sel_i ? (addr_i[7:0] ^ 8'h5a) : ~last_r;
  // remember what the lines showed
  always @(posedge clk_sys_i) begin
    last_r <= mem_data_o;
  end
endmodule : cppc_far_model
`default_nettype wire

// ===== sim/cppc_top_tb.sv
`default_nettype none
module cppc_top_tb;
  timeunit 1ns;
  timeprecision 1ns;
  localparam int N_RAND = 40;
  localparam int WD_NS = (N_RAND * 4 + 120) * 10 * 3;
  // stimulus, all set at time zero
  logic clk_sys_i = 1'b0;
  logic rst_n_i = 1'b0;
  logic [7:0] ctrl = 8'h00, l0 = 8'hff, l1 = 8'hff, l2 = 8'hff, l4 = 8'hff;
  logic [7:0] a1 = 8'h00, a4 = 8'h00, wd = 8'h00, p1_ext = 8'h00;
  logic [15:0] addr = 16'h0000;
  logic [5:0] sr = 6'h00;
  logic [1:0] tog = 2'h0;
  logic pd = 1'b0, em = 1'b0, aph = 1'b0, wr = 1'b0, pad = 1'b0;
  logic txa = 1'b0, txb = 1'b0, bus_bit = 1'b1;
  logic [31:0] seed = 32'h00000013;
  logic [7:0] ctab [4] = '{8'h01, 8'h21, 8'h00, 8'h20};
  int errors = 0, check_count = 0;
  // design outputs and resolved pins
  logic rxb, evr, rsr, ref_oe, ref_on, cmp;
  logic [3:0] cap;
  logic [7:0] rdata, p0o, p0oe, p1o, p1oe, p2o, p2oe, p4o, p4oe, mem;
  logic [7:0] p0_pin, p1_pin;
  wire logic rd_sel = em & ~aph & ~wr;
  cppc_top cppc_top_i (
    .clk_sys_i(clk_sys_i), .rst_n_i(rst_n_i), .can_ctrl_i(ctrl),
    .powerdown_i(pd), .ext_mem_i(em), .ext_addr_phase_i(aph),
    .ext_addr_i(addr), .ext_wdata_i(wd), .ext_wr_i(wr),
    .p0_latch_i(l0), .p1_latch_i(l1), .p2_latch_i(l2), .p4_latch_i(l4),
    .p1_alt_en_i(a1), .p4_alt_en_i(a4), .can_tx_a_i(txa),
    .can_tx_b_i(txb), .can_rx_bit_o(rxb), .cmp_sr_i(sr), .cmp_tog_i(tog),
    .capture_or_irq_o(cap), .timer2_event_rise_o(evr),
    .timer2_reset_rise_o(rsr), .can_rx_pos_above_neg_i(cmp),
    .ref_out_en_o(ref_oe), .ref_source_on_o(ref_on), .p0_pin_i(p0_pin),
    .p0_o(p0o), .p0_oe_o(p0oe), .p0_rdata_o(rdata), .p1_pin_i(p1_pin),
    .p1_o(p1o), .p1_oe_o(p1oe), .p2_o(p2o), .p2_oe_o(p2oe), .p4_o(p4o),
    .p4_oe_o(p4oe)
  );
  cppc_far_model cppc_far_model_i (
    .clk_sys_i(clk_sys_i), .bus_bit_i(bus_bit), .rd_sel_i(rd_sel),
    .addr_i(addr), .pos_above_neg_o(cmp), .mem_data_o(mem)
  );
  // free-running clock
  always #5 clk_sys_i = ~clk_sys_i;
  // a driving design wins the pin, else the far side's level
  assign p0_pin = (p0o & p0oe) | (mem & ~p0oe);
  assign p1_pin = (p1o & p1oe) | (p1_ext & ~p1oe);
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction : rnd
  task automatic chk8(input logic [7:0] got, input logic [7:0] exp,
      input string m);
    check_count++;
    if (got !== exp) begin
      errors++;
      $display("BAD %0t %s got %h exp %h", $time, m, got, exp);
    end
  endtask : chk8
  // p1 enable and value; tx pins follow the engine only while it runs
  function automatic logic [15:0] exp_p1();
    logic [7:0] e_oe, e_o;
    e_oe = ~l1;
    e_o = 8'h00;
    if (!ctrl[0]) begin
      e_oe[7:6] = e_oe[7:6] | a1[7:6];
      e_o[7:6] = a1[7:6] & {txb, txa};
    end
    return {e_oe, e_o};
  endfunction : exp_p1
  // p0 enable and value; as a plain port it only ever pulls low
  function automatic logic [15:0] exp_p0();
    logic [7:0] e_oe, e_o;
    e_oe = em ? ((aph | wr) ? 8'hff : 8'h00) : ~l0;
    e_o = em ? (aph ? addr[7:0] : wd) : 8'h00;
    return {e_oe, e_o & e_oe};
  endfunction : exp_p0
  // static outputs worked out from the present inputs
  task automatic check_all();
    logic [15:0] e1, e0;
    e1 = exp_p1();
    e0 = exp_p0();
    chk8(p1oe, e1[15:8], "p1 enable");
    chk8(p1o & p1oe, e1[7:0], "p1 value");
    chk8(p4oe, a4 | ~l4, "p4 enable");
    chk8(p4o & p4oe, a4 & {tog, sr}, "p4 value");
    chk8(p0oe, e0[15:8], "p0 enable");
    chk8(p0o & p0oe, e0[7:0], "p0 value");
    chk8(p2oe, em ? 8'hff : ~l2, "p2 enable");
    chk8(p2o & p2oe, em ? addr[15:8] : 8'h00, "p2 value");
    if (rd_sel) chk8(rdata, addr[7:0] ^ 8'h5a, "p0 read");
    chk8({4'h0, cap}, {4'h0, p1_ext[3:0] & a1[3:0]}, "capture");
    chk8({5'h00, ref_oe, ref_on, rxb},
      {5'h00, ctrl[5], ~(ctrl[0] & pd), bus_bit}, "ref rx");
  endtask : check_all
  task automatic settle_check();
    repeat (3) @(negedge clk_sys_i);
    check_all();
  endtask : settle_check
  task automatic do_reset();
    rst_n_i = 1'b0;
    repeat (6) @(negedge clk_sys_i);
    chk8({5'h00, ref_oe, ref_on, rxb}, 8'h07, "reset ref rx");
    chk8(p1oe & 8'hc0, 8'h00, "reset tx float");
    rst_n_i = 1'b1;
    $display("test reset done");
  endtask : do_reset
  // one rising edge on a timer input, enabled or not
  task automatic pulse_test(input int b, input logic en);
    a1[b] = en;
    p1_ext[b] = 1'b0;
    repeat (3) @(negedge clk_sys_i);
    p1_ext[b] = 1'b1;
    @(negedge clk_sys_i);
    chk8({6'h00, evr, rsr}, {6'h00, en & (b == 4), en & (b == 5)}, "rise");
    @(negedge clk_sys_i);
    chk8({6'h00, evr, rsr}, 8'h00, "rise end");
  endtask : pulse_test
  task automatic tally_and_finish();
    $display("counts: %0d checks, %0d mismatches", check_count, errors);
    if (errors == 0 && check_count > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask : tally_and_finish
  // main sequence
  initial begin
    do_reset();
    pd = 1'b1;
    a1 = 8'hc0;
    txa = 1'b1;
    for (int k = 0; k < 8; k++) begin
      ctrl = ctab[k % 4];
      l1 = k < 4 ? 8'hff : 8'h3f;
      settle_check();
    end
    $display("test control corners done");
    bus_bit = 1'b0;
    repeat (2) @(negedge clk_sys_i);
    chk8({7'h00, rxb}, 8'h01, "rx too early");
    @(negedge clk_sys_i);
    chk8({7'h00, rxb}, 8'h00, "rx dominant");
    bus_bit = 1'b1;
    settle_check();
    $display("test receive done");
    for (int k = 0; k < 4; k++) pulse_test(4 + k % 2, k > 1);
    $display("test timer edges done");
    for (int n = 0; n < N_RAND; n++) begin
      {ctrl, l0, l1, l2} = rnd();
      {l4, a1, a4, wd} = rnd();
      {addr, sr, tog, pd, em, aph, wr, txa, txb, bus_bit, pad} = rnd();
      p1_ext = 8'(rnd());
      l1 = l1 | a1;
      l4 = l4 | a4;
      settle_check();
    end
    $display("test random done");
    ctrl = 8'h01;
    do_reset();
    settle_check();
    $display("test second reset done");
    tally_and_finish();
  end
  // cut a hang short
  initial begin
    #(WD_NS);
    errors++;
    $display("BAD %0t watchdog ran out", $time);
    tally_and_finish();
  end
endmodule : cppc_top_tb
`default_nettype wire
